// *** pkg/card_framer_defs.svh ***
`ifndef CARD_FRAMER_DEFS_SVH
`define CARD_FRAMER_DEFS_SVH

// property identifiers of the four marker settings
`define PROP_CARD_LEAD   8'h0B
`define PROP_CARD_TRAIL  8'h0C
`define PROP_TRK_LEAD    8'h0D
`define PROP_TRK_TRAIL   8'h0E

// storage slot of each marker, slot = identifier - PROP_CARD_LEAD
`define SLOT_CARD_LEAD   2'h0
`define SLOT_CARD_TRAIL  2'h1
`define SLOT_TRK_LEAD    2'h2
`define SLOT_TRK_TRAIL   2'h3

// command numbers, expected lengths, result codes
`define CMD_GET          8'h00
`define CMD_SET          8'h01
`define LEN_GET          8'h01
`define LEN_SET          8'h02
`define RES_OK           8'h00
`define RES_BAD          8'h01
`define RSP_LEN_NONE     8'h00
`define RSP_LEN_VALUE    8'h01

// marker values
`define MARKER_NONE      8'h00
`define MARKER_MAX       8'h7F
`define MARKER_RESET_ALL 32'h0000_0000

// command byte positions
`define POS_NUM          9'h000
`define POS_LEN          9'h001
`define POS_ID           9'h002
`define POS_VAL          9'h003
`define RSP_CNT_GET      2'h3
`define RSP_CNT_SET      2'h2

`endif

// *** pkg/card_framer_pkg.sv ***
package card_framer_pkg;

   typedef logic [7:0] byte_type;
   typedef logic [1:0] slot_type;
   typedef byte_type [3:0] marker_set_type;

   typedef enum logic [5:0] {
      S_IDLE       = 6'h01,
      S_CARD_LEAD  = 6'h02,
      S_TRK_LEAD   = 6'h04,
      S_DATA       = 6'h08,
      S_TRK_TRAIL  = 6'h10,
      S_CARD_TRAIL = 6'h20
   } frame_state_type;

   typedef enum logic [2:0] {
      C_RECV = 3'h1,
      C_EXEC = 3'h2,
      C_RSP  = 3'h4
   } cmd_state_type;

endpackage

// *** pkg/marker_store_if.sv ***
`timescale 1ns/100ps
interface marker_store_if;
   import card_framer_pkg::*;

   logic           wr_en;
   slot_type       wr_slot;
   byte_type       wr_data;
   logic           clear;
   marker_set_type rd_bus;

   modport owner (output wr_en, output wr_slot, output wr_data, output clear, input rd_bus);
   modport store (input wr_en, input wr_slot, input wr_data, input clear, output rd_bus);
endinterface

// *** logic/marker_setting_store.sv ***
`timescale 1ns/100ps
`include "card_framer_defs.svh"
module marker_setting_store (
   input  wire logic     i_clk_sys,
   input  wire logic     i_arst_n,
   marker_store_if.store store_port
);
   import card_framer_pkg::*;

   // stands in for non-volatile cells: deliberately not cleared by reset
   marker_set_type mem_reg;

   always_ff @(posedge i_clk_sys) begin
      if (store_port.clear) begin
         mem_reg <= `MARKER_RESET_ALL;
      end else if (store_port.wr_en) begin
         mem_reg[store_port.wr_slot] <= store_port.wr_data;
      end
   end

   assign store_port.rd_bus = mem_reg;

   a_store_keeps_write: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (store_port.wr_en && !store_port.clear) |=>
         store_port.rd_bus[$past(store_port.wr_slot)] == $past(store_port.wr_data))
      else $error("stored marker differs from written value");

   a_factory_zero: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      store_port.clear |=> store_port.rd_bus == `MARKER_RESET_ALL)
      else $error("factory clear left a marker nonzero");
endmodule

// *** logic/card_framer_top.sv ***
// Summary of operation
// - card leader sent once before card data
// - card trailer sent once after card data
// - track leader sent right before track data
// - track trailer sent right after track data
// - zero setting sends nothing at that place
// - values 1 to 127 send that character
// - settings kept in non-volatile store
// - changed settings take effect after power cycle
// - get/set commands by number, length, identifier
`timescale 1ns/100ps
`include "card_framer_defs.svh"
module card_framer_top (
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_arst_n,
   input  wire logic                     i_factory_clear,
   input  wire logic                     i_cmd_valid,
   input  wire card_framer_pkg::byte_type i_cmd_data,
   output logic                          o_cmd_ready,
   output logic                          o_rsp_valid,
   output card_framer_pkg::byte_type     o_rsp_data,
   input  wire logic                     i_rsp_ready,
   input  wire logic                     i_trk_valid,
   input  wire card_framer_pkg::byte_type i_trk_data,
   input  wire logic                     i_trk_eot,
   input  wire logic                     i_trk_eoc,
   output logic                          o_trk_ready,
   output logic                          o_chr_valid,
   output card_framer_pkg::byte_type     o_chr_data,
   input  wire logic                     i_chr_ready,
   output logic                          o_frame_busy
);
   import card_framer_pkg::*;

   marker_store_if store_bus ();
   marker_setting_store u_store (
      .i_clk_sys  (i_clk_sys),
      .i_arst_n   (i_arst_n),
      .store_port (store_bus.store)
   );

   marker_set_type  active_reg;
   logic            load_pending_reg;
   frame_state_type frame_reg;
   frame_state_type frame_next;
   logic            hold_valid_reg;
   logic            hold_valid_next;
   byte_type        hold_data_reg;
   logic            hold_eot_reg;
   logic            hold_eoc_reg;
   logic            last_trk_reg;
   logic            trk_accept;
   logic            take_hold;
   logic            out_free;
   logic            emit;
   logic            emit_marker;
   byte_type        emit_data;
   logic            marker_out_reg;
   cmd_state_type   cmd_reg;
   cmd_state_type   cmd_next;
   logic [8:0]      pos_reg;
   byte_type        cmd_num_reg;
   byte_type        cmd_len_reg;
   byte_type        cmd_id_reg;
   byte_type        cmd_val_reg;
   logic            cmd_take;
   logic            cmd_last;
   logic            id_ok;
   logic            get_ok;
   logic            set_ok;
   slot_type        cmd_slot;
   byte_type        rsp_len_reg;
   byte_type        rsp_val_reg;
   logic [1:0]      rsp_idx_reg;
   logic [1:0]      rsp_cnt_reg;

   wire byte_type card_lead  = active_reg[`SLOT_CARD_LEAD];
   wire byte_type card_trail = active_reg[`SLOT_CARD_TRAIL];
   wire byte_type trk_lead   = active_reg[`SLOT_TRK_LEAD];
   wire byte_type trk_trail  = active_reg[`SLOT_TRK_TRAIL];

   // the working copy is taken once, right after reset release, so a set
   // command never changes the framing of the current power-on session
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         active_reg       <= `MARKER_RESET_ALL;
         load_pending_reg <= 1'b1;
      end else if (load_pending_reg) begin
         active_reg       <= store_bus.rd_bus;
         load_pending_reg <= 1'b0;
      end
   end

   // single-entry holding stage; halves throughput but keeps ready registered
   assign trk_accept      = i_trk_valid && o_trk_ready;
   assign hold_valid_next = trk_accept || (hold_valid_reg && !take_hold);

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hold_valid_reg <= 1'b0;
         hold_data_reg  <= 8'h00;
         hold_eot_reg   <= 1'b0;
         hold_eoc_reg   <= 1'b0;
         o_trk_ready    <= 1'b0;
      end else begin
         hold_valid_reg <= hold_valid_next;
         o_trk_ready    <= !hold_valid_next && !load_pending_reg;
         if (trk_accept) begin
            hold_data_reg <= i_trk_data;
            hold_eot_reg  <= i_trk_eot;
            hold_eoc_reg  <= i_trk_eoc;
         end
      end
   end

   assign out_free = !o_chr_valid || i_chr_ready;
   always_comb begin
      frame_next  = frame_reg;
      emit        = 1'b0;
      emit_marker = 1'b0;
      emit_data   = 8'h00;
      take_hold   = 1'b0;
      case (frame_reg)
         S_IDLE: begin
            if (hold_valid_reg) begin
               frame_next = (card_lead != `MARKER_NONE) ? S_CARD_LEAD : S_TRK_LEAD;
            end
         end
         S_CARD_LEAD: begin
            if (out_free) begin
               emit        = 1'b1;
               emit_marker = 1'b1;
               emit_data   = card_lead;
               frame_next  = S_TRK_LEAD;
            end
         end
         S_TRK_LEAD: begin
            if (trk_lead == `MARKER_NONE) begin
               frame_next = S_DATA;
            end else if (out_free) begin
               emit        = 1'b1;
               emit_marker = 1'b1;
               emit_data   = trk_lead;
               frame_next  = S_DATA;
            end
         end
         S_DATA: begin
            if (hold_valid_reg && out_free) begin
               emit      = 1'b1;
               emit_data = hold_data_reg;
               take_hold = 1'b1;
               if (hold_eot_reg) begin
                  frame_next = S_TRK_TRAIL;
               end
            end
         end
         S_TRK_TRAIL: begin
            if (trk_trail == `MARKER_NONE) begin
               frame_next = last_trk_reg ? S_CARD_TRAIL : S_TRK_LEAD;
            end else if (out_free) begin
               emit        = 1'b1;
               emit_marker = 1'b1;
               emit_data   = trk_trail;
               frame_next  = last_trk_reg ? S_CARD_TRAIL : S_TRK_LEAD;
            end
         end
         S_CARD_TRAIL: begin
            if (card_trail == `MARKER_NONE) begin
               frame_next = S_IDLE;
            end else if (out_free) begin
               emit        = 1'b1;
               emit_marker = 1'b1;
               emit_data   = card_trail;
               frame_next  = S_IDLE;
            end
         end
         default: begin
            frame_next = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         frame_reg    <= S_IDLE;
         last_trk_reg <= 1'b0;
         o_frame_busy <= 1'b0;
      end else begin
         frame_reg    <= frame_next;
         o_frame_busy <= (frame_next != S_IDLE);
         if (take_hold && hold_eot_reg) begin
            last_trk_reg <= hold_eoc_reg;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_chr_valid    <= 1'b0;
         o_chr_data     <= 8'h00;
         marker_out_reg <= 1'b0;
      end else if (emit) begin
         o_chr_valid    <= 1'b1;
         o_chr_data     <= emit_data;
         marker_out_reg <= emit_marker;
      end else if (i_chr_ready) begin
         o_chr_valid    <= 1'b0;
         marker_out_reg <= 1'b0;
      end
   end

   // command parser: number, length, then length bytes (identifier, value)
   assign cmd_take = i_cmd_valid && o_cmd_ready;
   assign cmd_last = (pos_reg == `POS_LEN) ? (i_cmd_data == 8'h00)
                   : (pos_reg > `POS_LEN) && (pos_reg == ({1'b0, cmd_len_reg} + 9'h001));
   assign id_ok    = (cmd_id_reg >= `PROP_CARD_LEAD) && (cmd_id_reg <= `PROP_TRK_TRAIL);
   assign cmd_slot = slot_type'(cmd_id_reg - `PROP_CARD_LEAD);
   assign get_ok   = (cmd_num_reg == `CMD_GET) && (cmd_len_reg == `LEN_GET) && id_ok;
   assign set_ok   = (cmd_num_reg == `CMD_SET) && (cmd_len_reg == `LEN_SET) && id_ok
                     && (cmd_val_reg <= `MARKER_MAX);

   assign store_bus.wr_en   = (cmd_reg == C_EXEC) && set_ok;
   assign store_bus.wr_slot = cmd_slot;
   assign store_bus.wr_data = cmd_val_reg;
   assign store_bus.clear   = i_factory_clear;

   always_comb begin
      cmd_next = cmd_reg;
      case (cmd_reg)
         C_RECV: begin
            if (cmd_take && cmd_last) begin
               cmd_next = C_EXEC;
            end
         end
         C_EXEC: begin
            cmd_next = C_RSP;
         end
         C_RSP: begin
            if (i_rsp_ready && (rsp_idx_reg == rsp_cnt_reg)) begin
               cmd_next = C_RECV;
            end
         end
         default: begin
            cmd_next = C_RECV;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cmd_reg     <= C_RECV;
         o_cmd_ready <= 1'b0;
         pos_reg     <= `POS_NUM;
         cmd_num_reg <= 8'h00;
         cmd_len_reg <= 8'h00;
         cmd_id_reg  <= 8'h00;
         cmd_val_reg <= 8'h00;
      end else begin
         cmd_reg     <= cmd_next;
         o_cmd_ready <= (cmd_next == C_RECV) && !(cmd_take && cmd_last);
         if (cmd_take) begin
            // bytes past the value are taken and dropped
            pos_reg <= cmd_last ? `POS_NUM : pos_reg + 9'h001;
            case (pos_reg)
               `POS_NUM: cmd_num_reg <= i_cmd_data;
               `POS_LEN: cmd_len_reg <= i_cmd_data;
               `POS_ID:  cmd_id_reg  <= i_cmd_data;
               `POS_VAL: cmd_val_reg <= i_cmd_data;
               default:  cmd_val_reg <= cmd_val_reg;
            endcase
            if (pos_reg == `POS_NUM) begin
               cmd_id_reg  <= 8'h00;
               cmd_val_reg <= 8'h00;
            end
         end
      end
   end

   // get answers the stored value, which may not yet be the one in use
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rsp_valid <= 1'b0;
         o_rsp_data  <= 8'h00;
         rsp_len_reg <= 8'h00;
         rsp_val_reg <= 8'h00;
         rsp_idx_reg <= 2'h0;
         rsp_cnt_reg <= 2'h0;
      end else if (cmd_reg == C_EXEC) begin
         o_rsp_valid <= 1'b1;
         o_rsp_data  <= (get_ok || set_ok) ? `RES_OK : `RES_BAD;
         rsp_len_reg <= get_ok ? `RSP_LEN_VALUE : `RSP_LEN_NONE;
         rsp_val_reg <= store_bus.rd_bus[cmd_slot];
         rsp_cnt_reg <= get_ok ? `RSP_CNT_GET : `RSP_CNT_SET;
         rsp_idx_reg <= 2'h1;
      end else if ((cmd_reg == C_RSP) && i_rsp_ready) begin
         rsp_idx_reg <= rsp_idx_reg + 2'h1;
         if (rsp_idx_reg == rsp_cnt_reg) begin
            o_rsp_valid <= 1'b0;
         end else begin
            o_rsp_data <= (rsp_idx_reg == 2'h1) ? rsp_len_reg : rsp_val_reg;
         end
      end
   end

   a_card_lead_out: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (frame_reg == S_CARD_LEAD && out_free) |=>
         o_chr_valid && marker_out_reg && o_chr_data == card_lead && frame_reg == S_TRK_LEAD)
      else $error("card leader not sent");
   a_card_trail_out: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (frame_reg == S_CARD_TRAIL && out_free && card_trail != `MARKER_NONE) |=>
         o_chr_valid && o_chr_data == card_trail && frame_reg == S_IDLE)
      else $error("card trailer not sent");
   a_trk_lead_out: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (frame_reg == S_TRK_LEAD && out_free && trk_lead != `MARKER_NONE) |=>
         o_chr_valid && o_chr_data == trk_lead && frame_reg == S_DATA)
      else $error("track leader not sent");
   a_trk_trail_out: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (frame_reg == S_TRK_TRAIL && out_free && trk_trail != `MARKER_NONE) |=>
         o_chr_valid && marker_out_reg && o_chr_data == trk_trail)
      else $error("track trailer not sent");
   a_zero_skipped: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      marker_out_reg |-> o_chr_data != `MARKER_NONE)
      else $error("zero marker was sent");
   a_marker_ascii: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      marker_out_reg |-> o_chr_data <= `MARKER_MAX)
      else $error("marker outside ascii range");
   a_settings_frozen: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (!load_pending_reg && !$past(load_pending_reg)) |-> $stable(active_reg))
      else $error("active markers changed without power cycle");
   a_frame_order: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (frame_reg == S_DATA) |=> (frame_reg == S_DATA || frame_reg == S_TRK_TRAIL))
      else $error("data state left out of order");
   a_cmd_result: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (cmd_reg == C_EXEC) |=> o_rsp_valid && cmd_reg == C_RSP
         && o_rsp_data == ((get_ok || set_ok) ? `RES_OK : `RES_BAD))
      else $error("result code wrong after command");
endmodule

// *** verif/char_sink_model.sv ***
`timescale 1ns/100ps
module char_sink_model (
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_stall,
   input  wire logic                      i_chr_valid,
   input  wire card_framer_pkg::byte_type i_chr_data,
   output logic                           o_chr_ready
);
   import card_framer_pkg::*;

   // every character the host took, in arrival order
   byte_type rx_q[$];

   // a slow host stalls at random, the framer must hold its character meanwhile
   always @(posedge i_clk_sys) begin
      if (i_chr_valid === 1'b1 && o_chr_ready === 1'b1) begin
         rx_q.push_back(i_chr_data);
      end
      o_chr_ready <= i_stall ? 1'(($urandom % 3) != 0) : 1'b1;
   end
endmodule

// *** verif/card_framer_top_tb.sv ***
`timescale 1ns/100ps
`include "card_framer_defs.svh"
module card_framer_top_tb;
   import card_framer_pkg::*;

   logic     clk_sys = 1'b0;
   logic     arst_n = 1'b0;
   logic     factory_clear = 1'b1;
   logic     cmd_valid = 1'b0;
   byte_type cmd_data = 8'h00;
   logic     cmd_ready;
   logic     rsp_valid;
   byte_type rsp_data;
   logic     rsp_ready = 1'b0;
   logic     trk_valid = 1'b0;
   byte_type trk_data = 8'h00;
   logic     trk_eot = 1'b0;
   logic     trk_eoc = 1'b0;
   logic     trk_ready;
   logic     chr_valid;
   byte_type chr_data;
   logic     chr_ready;
   logic     frame_busy;
   logic     stall = 1'b0;
   int       num_errors = 0;
   int       checks = 0;
   int       cycles = 0;
   int       store_m[4] = '{0, 0, 0, 0};
   int       work_m[4] = '{0, 0, 0, 0};
   byte_type exp_q[$];

   card_framer_top i_card_framer_top (
      .i_clk_sys       (clk_sys),
      .i_arst_n        (arst_n),
      .i_factory_clear (factory_clear),
      .i_cmd_valid     (cmd_valid),
      .i_cmd_data      (cmd_data),
      .o_cmd_ready     (cmd_ready),
      .o_rsp_valid     (rsp_valid),
      .o_rsp_data      (rsp_data),
      .i_rsp_ready     (rsp_ready),
      .i_trk_valid     (trk_valid),
      .i_trk_data      (trk_data),
      .i_trk_eot       (trk_eot),
      .i_trk_eoc       (trk_eoc),
      .o_trk_ready     (trk_ready),
      .o_chr_valid     (chr_valid),
      .o_chr_data      (chr_data),
      .i_chr_ready     (chr_ready),
      .o_frame_busy    (frame_busy)
   );

   char_sink_model i_char_sink_model (
      .i_clk_sys   (clk_sys),
      .i_stall     (stall),
      .i_chr_valid (chr_valid),
      .i_chr_data  (chr_data),
      .o_chr_ready (chr_ready)
   );

   always #2 clk_sys = ~clk_sys;

   // the host takes responses at a random pace
   always @(posedge clk_sys) begin
      rsp_ready <= 1'($urandom % 2);
   end

   task automatic final_report;
      if (num_errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // a hung handshake ends the run here instead of spinning forever
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         final_report();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checks++;
      if (seen !== want) begin
         num_errors++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   // strobe held from first byte to last, response bytes taken on valid and ready
   task automatic command(input byte_type b[$], input byte_type want[$]);
      byte_type got;
      cmd_valid <= 1'b1;
      foreach (b[i]) begin
         cmd_data <= b[i];
         do @(posedge clk_sys); while (cmd_ready !== 1'b1);
      end
      cmd_valid <= 1'b0;
      foreach (want[i]) begin
         do @(posedge clk_sys); while (!(rsp_valid === 1'b1 && rsp_ready === 1'b1));
         got = rsp_data;
         check(got, want[i]);
      end
   endtask

   task automatic set_m(input int slot, input int val, input bit ok);
      command({`CMD_SET, `LEN_SET, byte_type'(`PROP_CARD_LEAD + slot), byte_type'(val)},
              {(ok ? `RES_OK : `RES_BAD), `RSP_LEN_NONE});
      if (ok) begin
         store_m[slot] = val;
      end
   endtask

   task automatic get_m(input int slot);
      command({`CMD_GET, `LEN_GET, byte_type'(`PROP_CARD_LEAD + slot)},
              {`RES_OK, `RSP_LEN_VALUE, byte_type'(store_m[slot])});
   endtask

   // power loss: working copy reloads from the store
   task automatic power_cycle;
      arst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check({3'h0, cmd_ready, trk_ready, chr_valid, rsp_valid, frame_busy}, 8'h00);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      work_m = store_m;
   endtask

   task automatic run_card(input int ntrk);
      int       n;
      byte_type d;
      exp_q.delete();
      i_char_sink_model.rx_q.delete();
      if (work_m[0] != 0) exp_q.push_back(byte_type'(work_m[0]));
      trk_valid <= 1'b1;
      for (int t = 0; t < ntrk; t++) begin
         n = 1 + $urandom % 4;
         if (work_m[2] != 0) exp_q.push_back(byte_type'(work_m[2]));
         for (int k = 0; k < n; k++) begin
            d = byte_type'($urandom);
            exp_q.push_back(d);
            trk_data <= d;
            trk_eot <= (k == n - 1);
            trk_eoc <= (k == n - 1) && (t == ntrk - 1);
            do @(posedge clk_sys); while (trk_ready !== 1'b1);
         end
         if (work_m[3] != 0) exp_q.push_back(byte_type'(work_m[3]));
      end
      trk_valid <= 1'b0;
      if (work_m[1] != 0) exp_q.push_back(byte_type'(work_m[1]));
      for (int w = 0; w < 300; w++) begin
         @(posedge clk_sys);
         if (frame_busy === 1'b0 && i_char_sink_model.rx_q.size() >= exp_q.size()) break;
      end
      repeat (4) @(posedge clk_sys);
      check(8'(i_char_sink_model.rx_q.size()), 8'(exp_q.size()));
      foreach (exp_q[i]) begin
         if (i < i_char_sink_model.rx_q.size()) begin
            check(i_char_sink_model.rx_q[i], exp_q[i]);
         end
      end
   endtask

   initial begin
      int v;
      void'($urandom(34866));
      // store has no reset of its own, so it is cleared from the factory line
      repeat (10) @(posedge clk_sys);
      check({3'h0, cmd_ready, trk_ready, chr_valid, rsp_valid, frame_busy}, 8'h00);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      factory_clear <= 1'b0;
      for (int s = 0; s < 4; s++) get_m(s);
      run_card(2);
      // passes 0 to 3 each zero one marker; every pass puts the top code on another
      for (int k = 0; k < 5; k++) begin
         for (int s = 0; s < 4; s++) begin
            v = 1 + $urandom % 127;
            if (s == k) v = 0;
            if (s == (k + 1) % 4) v = 127;
            set_m(s, v, 1'b1);
         end
         if (k == 0) run_card(1);
         power_cycle();
         for (int s = 0; s < 4; s++) get_m(s);
         stall <= 1'(k % 2);
         run_card(1 + k % 3);
      end
      command({8'h02, 8'h02, `PROP_CARD_LEAD, 8'h11}, {`RES_BAD, `RSP_LEN_NONE});
      command({`CMD_GET, 8'h02, `PROP_CARD_LEAD, 8'h00}, {`RES_BAD, `RSP_LEN_NONE});
      set_m(4, 8'h21, 1'b0);
      set_m(0, 8'h80, 1'b0);
      for (int s = 0; s < 4; s++) get_m(s);
      factory_clear <= 1'b1;
      @(posedge clk_sys);
      factory_clear <= 1'b0;
      store_m = '{0, 0, 0, 0};
      for (int s = 0; s < 4; s++) get_m(s);
      power_cycle();
      run_card(2);
      final_report();
   end
endmodule
